//--- frame_security_policy_filter.sv
// per-frame protection, key and offset policy with receive discard
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - related peer: drop unprotected must-protect frames
// - data uses key id given with unit
// - protected commands use installed relationship key
// - beacon, acks, rts, cts, unused-reservation: never protected
// - group key commands always protected
// - data and aggregated data always protected
// - other commands and app frames optionally protected
// - key command offsets are zero
// - reservation and ranging offset equals payload length
// - aggregated offset is header plus pad
// - mode 0 sends unprotected, never relates
// - mode 0 discards every protected frame
// - mode 1 unprotected to mode 0, unrelated
// - mode 1 protects related; relates mode 1 only
// - mode 1 answers unrelated commands
// - mode 1 drops protected from unrelated peer
// - mode 1 drops unprotected must-protect from related
// - mode 2 relates only with mode 2
// - mode 2 needs handshake before data
// - mode 2 drops protected from unrelated peer
// - mode 2 drops unprotected must-protect always
// - relationship valid while pairwise key installed
// - advertise mode in beacon parameters
module frame_security_policy_filter
   import frame_security_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // configuration
   input wire logic [1:0] sec_mode_i,
   input wire logic pairwise_key_installed_i,
   // transmit request
   input wire logic tx_valid_i,
   input wire frame_security_pkg::tx_req_type tx_req_i,
   // transmit decision
   output logic tx_valid_o,
   output frame_security_pkg::tx_dec_type tx_dec_o,
   output logic tx_block_o,
   // relationship policy
   input wire logic peer_mode_valid_i,
   input wire logic [1:0] peer_mode_i,
   output logic relate_allowed_o,
   output logic cmd_answer_unrelated_o,
   // receive decision
   input wire logic rx_valid_i,
   input wire frame_security_pkg::rx_req_type rx_req_i,
   output logic rx_accept_o,
   output logic rx_drop_o,
   output frame_security_pkg::drop_cause_type rx_drop_cause_o,
   // beacon advertisement
   output logic [1:0] beacon_sec_mode_o
);
   import frame_security_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // mode register and classification

   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic mode_open;
   logic mode_mixed;
   logic mode_strict;
   logic next_mixed;
   logic next_strict;
   prot_req_type tx_req_class;
   prot_req_type rx_req_class;

   // where the offset of a protected frame comes from
   typedef enum logic [2:0] {
      OFS_ZERO = 3'h0,
      OFS_PAYLOAD = 3'h1,
      OFS_AGG_HEADER = 3'h2,
      OFS_APP = 3'h3,
      OFS_VARIABLE = 3'h4
   } offset_src_type;

   offset_src_type tx_offset_src;

   // reserved code folds onto the most restrictive mode
   assign mode_d = (sec_mode_i == SEC_MODE_RESERVED) ? SEC_MODE_STRICT : sec_mode_i;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         mode_q <= SEC_MODE_RESET;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign mode_open = (mode_q == SEC_MODE_OPEN);
   assign mode_mixed = (mode_q == SEC_MODE_MIXED);
   assign mode_strict = (mode_q == SEC_MODE_STRICT);
   // next-mode flags let the registered policy outputs move with mode_q
   assign next_mixed = (mode_d == SEC_MODE_MIXED);
   assign next_strict = (mode_d == SEC_MODE_STRICT);

   function automatic prot_req_type class_req(input frame_class_type fc);
      prot_req_type r;
      r = PROT_OPTIONAL;
      case (fc)
         FC_BEACON, FC_IMM_ACK, FC_BLOCK_ACK, FC_RTS, FC_CTS,
         FC_UNUSED_RES_ANNOUNCE, FC_UNUSED_RES_RESPONSE: begin
            r = PROT_NEVER;
         end
         FC_GROUP_KEY: begin
            r = PROT_ALWAYS;
         end
         FC_DATA, FC_AGG_DATA: begin
            r = PROT_ALWAYS;
         end
         default: begin
            r = PROT_OPTIONAL;
         end
      endcase
      return r;
   endfunction

   // encryption offset source of a protected frame, per class
   function automatic offset_src_type class_offset(input frame_class_type fc);
      offset_src_type s;
      s = OFS_ZERO;
      case (fc)
         FC_PAIRWISE_KEY, FC_GROUP_KEY: begin
            s = OFS_ZERO;
         end
         FC_RES_REQUEST, FC_RES_RESPONSE, FC_RANGE_MEAS: begin
            s = OFS_PAYLOAD;
         end
         FC_AGG_DATA: begin
            s = OFS_AGG_HEADER;
         end
         FC_APP_CONTROL, FC_APP_COMMAND: begin
            s = OFS_APP;
         end
         FC_PROBE, FC_DATA: begin
            s = OFS_VARIABLE;
         end
         default: begin
            s = OFS_ZERO;
         end
      endcase
      return s;
   endfunction

   assign tx_req_class = class_req(tx_req_i.frame_class);
   assign rx_req_class = class_req(rx_req_i.frame_class);
   assign tx_offset_src = class_offset(tx_req_i.frame_class);

   ////////////////////////////////////////////////////////////////////
   // relationship policy

   logic tx_related;
   logic rx_related;
   logic relate_d;
   logic answer_d;

   // relationship only counts while the pairwise key is installed
   assign tx_related = tx_req_i.peer_related && pairwise_key_installed_i && !mode_open;
   assign rx_related = rx_req_i.peer_related && pairwise_key_installed_i && !mode_open;

   // taken from the next mode so the outputs change together with mode_q
   always_comb begin
      relate_d = 1'b0;
      if (peer_mode_valid_i) begin
         if (next_mixed) begin
            relate_d = (peer_mode_i == SEC_MODE_MIXED);
         end else if (next_strict) begin
            relate_d = (peer_mode_i == SEC_MODE_STRICT);
         end else begin
            relate_d = 1'b0;
         end
      end
   end

   // unrelated commands are answered only below mode 2
   assign answer_d = !next_strict;

   // reset state matches mode 0: no relating, commands answered
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         relate_allowed_o <= 1'b0;
      end else begin
         relate_allowed_o <= relate_d;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cmd_answer_unrelated_o <= 1'b1;
      end else begin
         cmd_answer_unrelated_o <= answer_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transmit decision

   tx_dec_type dec_d;
   logic block_d;
   logic protect_d;
   logic tx_is_data;
   logic [KEY_ID_W-1:0] key_d;
   logic [LEN_W-1:0] offset_d;

   // clear unless related and in mode 1 or 2
   always_comb begin
      protect_d = 1'b0;
      if (tx_related && (mode_mixed || mode_strict)) begin
         case (tx_req_class)
            PROT_ALWAYS: protect_d = 1'b1;
            PROT_OPTIONAL: protect_d = tx_req_i.want_protect;
            default: protect_d = 1'b0;
         endcase
      end
   end

   // strict mode moves no data before the handshake completes
   assign block_d = mode_strict && !tx_related && (tx_req_class == PROT_ALWAYS);

   assign tx_is_data = (tx_req_i.frame_class == FC_DATA) || (tx_req_i.frame_class == FC_AGG_DATA);

   always_comb begin
      if (tx_is_data) begin
         key_d = tx_req_i.sdu_key_id;
      end else begin
         key_d = tx_req_i.pairwise_key_id;
      end
   end

   // unprotected frames carry a zero offset
   always_comb begin
      offset_d = OFFSET_ZERO;
      if (protect_d) begin
         case (tx_offset_src)
            OFS_PAYLOAD: offset_d = tx_req_i.payload_len;
            OFS_AGG_HEADER: offset_d = tx_req_i.agg_header_len;
            OFS_APP: offset_d = tx_req_i.app_offset;
            OFS_VARIABLE: offset_d = tx_req_i.var_offset;
            default: offset_d = OFFSET_ZERO;
         endcase
      end
   end

   always_comb begin
      dec_d.protect = protect_d;
      dec_d.key_id = key_d;
      dec_d.encryption_offset = offset_d;
   end

   // one-cycle pulse per request
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_valid_o <= 1'b0;
      end else begin
         tx_valid_o <= tx_valid_i;
      end
   end

   // decisions hold until the next request
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_dec_o <= '0;
      end else begin
         if (tx_valid_i) begin
            tx_dec_o <= dec_d;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         tx_block_o <= 1'b0;
      end else begin
         if (tx_valid_i) begin
            tx_block_o <= block_d;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // receive filter

   drop_cause_type cause_d;

   logic rx_unexpected;
   logic rx_missing;

   // protection only counts inside a live relationship
   assign rx_unexpected = rx_req_i.protected_frame && (mode_open || !rx_related);
   // must-protect sent clear: any peer in mode 2, related peer in mode 1
   assign rx_missing = !rx_req_i.protected_frame && (rx_req_class == PROT_ALWAYS)
      && (mode_strict || (mode_mixed && rx_related));

   always_comb begin
      cause_d = DROP_NONE;
      if (rx_unexpected) begin
         cause_d = DROP_UNEXPECTED_PROT;
      end else if (rx_missing) begin
         cause_d = DROP_MISSING_PROT;
      end
   end

   // each verdict stands for one cycle
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_accept_o <= 1'b0;
      end else begin
         rx_accept_o <= rx_valid_i && (cause_d == DROP_NONE);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_drop_o <= 1'b0;
      end else begin
         rx_drop_o <= rx_valid_i && (cause_d != DROP_NONE);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         rx_drop_cause_o <= DROP_NONE;
      end else begin
         rx_drop_cause_o <= rx_valid_i ? cause_d : DROP_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // beacon advertisement

   assign beacon_sec_mode_o = mode_q;

endmodule // frame_security_policy_filter

`default_nettype wire

//--- frame_security_pkg.sv
// shared types and constants for the frame security policy filter
package frame_security_pkg;

   // security mode codes
   localparam logic [1:0] SEC_MODE_OPEN = 2'h0;
   localparam logic [1:0] SEC_MODE_MIXED = 2'h1;
   localparam logic [1:0] SEC_MODE_STRICT = 2'h2;
   localparam logic [1:0] SEC_MODE_RESERVED = 2'h3;
   localparam logic [1:0] SEC_MODE_RESET = 2'h0;

   // frame class codes, from type and subtype decode upstream
   typedef enum logic [4:0] {
      FC_BEACON = 5'h00,
      FC_IMM_ACK = 5'h01,
      FC_BLOCK_ACK = 5'h02,
      FC_RTS = 5'h03,
      FC_CTS = 5'h04,
      FC_UNUSED_RES_ANNOUNCE = 5'h05,
      FC_UNUSED_RES_RESPONSE = 5'h06,
      FC_APP_CONTROL = 5'h07,
      FC_RES_REQUEST = 5'h08,
      FC_RES_RESPONSE = 5'h09,
      FC_PROBE = 5'h0A,
      FC_PAIRWISE_KEY = 5'h0B,
      FC_GROUP_KEY = 5'h0C,
      FC_RANGE_MEAS = 5'h0D,
      FC_APP_COMMAND = 5'h0E,
      FC_DATA = 5'h0F,
      FC_AGG_DATA = 5'h10
   } frame_class_type;

   // protection requirement of a frame class
   typedef enum logic [1:0] {
      PROT_NEVER = 2'h0,
      PROT_OPTIONAL = 2'h1,
      PROT_ALWAYS = 2'h2
   } prot_req_type;

   // receive discard cause
   typedef enum logic [1:0] {
      DROP_NONE = 2'h0,
      DROP_UNEXPECTED_PROT = 2'h1,
      DROP_MISSING_PROT = 2'h2
   } drop_cause_type;

   localparam int KEY_ID_W = 8;
   localparam int LEN_W = 12;
   localparam logic [LEN_W-1:0] OFFSET_ZERO = 12'h000;

   // transmit request from the frame builder
   typedef struct packed {
      frame_class_type frame_class;
      logic peer_related;
      logic peer_strict;
      logic want_protect;
      logic [KEY_ID_W-1:0] sdu_key_id;
      logic [KEY_ID_W-1:0] pairwise_key_id;
      logic [LEN_W-1:0] payload_len;
      logic [LEN_W-1:0] agg_header_len;
      logic [LEN_W-1:0] app_offset;
      logic [LEN_W-1:0] var_offset;
   } tx_req_type;

   // transmit decision
   typedef struct packed {
      logic protect;
      logic [KEY_ID_W-1:0] key_id;
      logic [LEN_W-1:0] encryption_offset;
   } tx_dec_type;

   // receive header summary
   typedef struct packed {
      frame_class_type frame_class;
      logic protected_frame;
      logic peer_related;
   } rx_req_type;

endpackage

//--- frame_security_props.sv
// port assertions for the frame security policy filter
`timescale 1ns/1ps
`default_nettype none
module frame_security_props
   import frame_security_pkg::*;
(
   // watched ports
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [1:0] sec_mode_i,
   input wire logic pairwise_key_installed_i,
   input wire logic tx_valid_i,
   input wire frame_security_pkg::tx_req_type tx_req_i,
   input wire logic tx_valid_o,
   input wire frame_security_pkg::tx_dec_type tx_dec_o,
   input wire logic rx_valid_i,
   input wire frame_security_pkg::rx_req_type rx_req_i,
   input wire logic rx_accept_o,
   input wire logic rx_drop_o,
   input wire frame_security_pkg::drop_cause_type rx_drop_cause_o,
   input wire logic [1:0] beacon_sec_mode_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_must_req;
      tx_valid_i && tx_req_i.peer_related && pairwise_key_installed_i && beacon_sec_mode_o != 2'h0
      && tx_req_i.frame_class inside {FC_GROUP_KEY, FC_DATA, FC_AGG_DATA};
   endsequence
   sequence s_data_sent;
      tx_valid_i && tx_req_i.frame_class inside {FC_DATA, FC_AGG_DATA} ##1 tx_dec_o.protect;
   endsequence
   a_must_protect: assert property (s_must_req |=> tx_valid_o && tx_dec_o.protect)
      else $error("must-protect frame sent clear");
   a_data_key: assert property (s_data_sent |-> tx_dec_o.key_id == $past(tx_req_i.sdu_key_id))
      else $error("data key id wrong");
   a_never_prot: assert property (tx_valid_i && tx_req_i.frame_class <= FC_UNUSED_RES_RESPONSE
      |=> !tx_dec_o.protect)
      else $error("clear-only frame protected");
   a_key_offset: assert property (tx_valid_i && tx_req_i.frame_class inside {FC_PAIRWISE_KEY,
      FC_GROUP_KEY} |=> tx_dec_o.encryption_offset == OFFSET_ZERO)
      else $error("key command offset not zero");
   a_res_offset: assert property (tx_valid_i && tx_req_i.frame_class inside {FC_RES_REQUEST,
      FC_RES_RESPONSE, FC_RANGE_MEAS} ##1 tx_dec_o.protect
      |-> tx_dec_o.encryption_offset == $past(tx_req_i.payload_len))
      else $error("reservation offset wrong");
   a_rx_verdict: assert property (rx_valid_i |=> rx_accept_o != rx_drop_o)
      else $error("rx verdict missing or double");
   a_open_drop: assert property (rx_valid_i && rx_req_i.protected_frame && beacon_sec_mode_o == 2'h0
      |=> rx_drop_o && rx_drop_cause_o == DROP_UNEXPECTED_PROT)
      else $error("open mode kept protected frame");
   a_strict_drop: assert property (rx_valid_i && !rx_req_i.protected_frame && beacon_sec_mode_o ==
      2'h2 && rx_req_i.frame_class inside {FC_GROUP_KEY, FC_DATA, FC_AGG_DATA}
      |=> rx_drop_o && rx_drop_cause_o == DROP_MISSING_PROT)
      else $error("strict mode kept clear frame");
   a_mode_map: assert property ($past(rst_n_i) |-> beacon_sec_mode_o ==
      ($past(sec_mode_i) == 2'h3 ? 2'h2 : $past(sec_mode_i)))
      else $error("advertised mode wrong");
endmodule // frame_security_props
`default_nettype wire

//--- peer_device_model.sv
// peer device model: received frame summaries and advertised mode
`timescale 1ns/1ps
`default_nettype none
module peer_device_model
   import frame_security_pkg::*;
(
   // from the bench
   input wire logic send_i,
   input wire logic adv_i,
   input wire frame_security_pkg::frame_class_type cls_i,
   input wire logic prot_i,
   input wire logic rel_i,
   input wire logic [1:0] mode_i,
   // toward the filter
   output logic rx_valid_o,
   output frame_security_pkg::rx_req_type rx_req_o,
   output logic mode_valid_o,
   output logic [1:0] mode_o
);
   // clear must-protect frames only when the bench commands them
   assign rx_valid_o = send_i;
   assign rx_req_o = '{frame_class: cls_i, protected_frame: send_i ? prot_i : ~prot_i,
      peer_related: rel_i};
   // mode is only known while the peer's beacons are heard
   assign mode_valid_o = adv_i;
   assign mode_o = mode_i;
endmodule // peer_device_model
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the frame security policy filter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import frame_security_pkg::*;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, pairwise_key_installed_i = 1'b1, tx_valid_i = 1'b0;
   logic send = 1'b0, prot = 1'b0, rel = 1'b0, adv = 1'b1, peer_mode_valid_i, rx_valid_i;
   logic tx_valid_o, tx_block_o, relate_allowed_o, cmd_answer_unrelated_o, rx_accept_o, rx_drop_o;
   logic [1:0] sec_mode_i = 2'h0, pmode = 2'h1, peer_mode_i, beacon_sec_mode_o;
   frame_class_type cls = FC_DATA;
   tx_req_type tx_req_i = '0;
   tx_dec_type tx_dec_o;
   rx_req_type rx_req_i;
   drop_cause_type rx_drop_cause_o;
   int num_errors = 0;
   int comparisons = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   frame_security_policy_filter uut (.clk_sys_i, .rst_n_i, .sec_mode_i, .pairwise_key_installed_i,
      .tx_valid_i, .tx_req_i, .tx_valid_o, .tx_dec_o, .tx_block_o, .peer_mode_valid_i,
      .peer_mode_i, .relate_allowed_o, .cmd_answer_unrelated_o, .rx_valid_i, .rx_req_i,
      .rx_accept_o, .rx_drop_o, .rx_drop_cause_o, .beacon_sec_mode_o);
   peer_device_model peer (.send_i(send), .adv_i(adv), .cls_i(cls), .prot_i(prot), .rel_i(rel),
      .mode_i(pmode), .rx_valid_o(rx_valid_i), .rx_req_o(rx_req_i),
      .mode_valid_o(peer_mode_valid_i), .mode_o(peer_mode_i));
   task automatic chk(input logic [31:0] seen, exp, input string nm);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tx(input frame_class_type c, input logic r, w, p, input logic [11:0] o);
      @(negedge clk_sys_i);
      tx_req_i.frame_class = c;
      tx_req_i.peer_related = r;
      tx_req_i.want_protect = w;
      tx_valid_i = 1'b1;
      @(negedge clk_sys_i);
      tx_valid_i = 1'b0;
      chk(tx_valid_o, 1'b1, "tx_valid");
      chk(tx_dec_o.protect, p, "protect");
      chk(tx_dec_o.encryption_offset, p ? o : 12'h000, "offset");
      if (p) chk(tx_dec_o.key_id, c inside {FC_DATA, FC_AGG_DATA} ? 8'hA5 : 8'h3C, "key");
   endtask
   task automatic rx(input frame_class_type c, input logic pr, rl, input drop_cause_type d);
      @(negedge clk_sys_i);
      cls = c;
      prot = pr;
      rel = rl;
      send = 1'b1;
      @(negedge clk_sys_i);
      send = 1'b0;
      chk(rx_drop_o, d != DROP_NONE, "rx_drop");
      chk(rx_accept_o, d == DROP_NONE, "rx_accept");
      chk(rx_drop_cause_o, d, "drop_cause");
   endtask
   task automatic setm(input logic [1:0] m, e);
      @(negedge clk_sys_i);
      sec_mode_i = m;
      @(negedge clk_sys_i);
      chk(beacon_sec_mode_o, e, "beacon_mode");
   endtask
   task automatic complete_run;
      if (num_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      tx_req_i.sdu_key_id = 8'hA5;
      tx_req_i.pairwise_key_id = 8'h3C;
      tx_req_i.payload_len = 12'h040;
      tx_req_i.agg_header_len = 12'h018;
      tx_req_i.app_offset = 12'h0AB;
      tx_req_i.var_offset = 12'h077;
      repeat (6) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      setm(2'h0, 2'h0);
      tx(FC_DATA, 1'b1, 1'b1, 1'b0, 12'h000);
      rx(FC_PROBE, 1'b1, 1'b1, DROP_UNEXPECTED_PROT);
      chk(relate_allowed_o, 1'b0, "relate");
      setm(2'h1, 2'h1);
      chk(relate_allowed_o, 1'b1, "relate");
      chk(cmd_answer_unrelated_o, 1'b1, "answer");
      tx(FC_DATA, 1'b1, 1'b0, 1'b1, 12'h077);
      tx(FC_AGG_DATA, 1'b1, 1'b0, 1'b1, 12'h018);
      tx(FC_GROUP_KEY, 1'b1, 1'b0, 1'b1, 12'h000);
      tx(FC_PAIRWISE_KEY, 1'b1, 1'b1, 1'b1, 12'h000);
      tx(FC_RES_RESPONSE, 1'b1, 1'b1, 1'b1, 12'h040);
      tx(FC_RANGE_MEAS, 1'b1, 1'b1, 1'b1, 12'h040);
      tx(FC_APP_CONTROL, 1'b1, 1'b1, 1'b1, 12'h0AB);
      tx(FC_PROBE, 1'b1, 1'b0, 1'b0, 12'h000);
      for (int i = 0; i < 7; i++) tx(frame_class_type'(i), 1'b1, 1'b1, 1'b0, 12'h000);
      tx(FC_DATA, 1'b0, 1'b1, 1'b0, 12'h000);
      rx(FC_DATA, 1'b1, 1'b0, DROP_UNEXPECTED_PROT);
      rx(FC_DATA, 1'b0, 1'b1, DROP_MISSING_PROT);
      rx(FC_DATA, 1'b0, 1'b0, DROP_NONE);
      pairwise_key_installed_i = 1'b0;
      tx(FC_DATA, 1'b1, 1'b0, 1'b0, 12'h000);
      pairwise_key_installed_i = 1'b1;
      setm(2'h3, 2'h2);
      chk(relate_allowed_o, 1'b0, "relate");
      pmode = 2'h2;
      @(negedge clk_sys_i);
      chk(relate_allowed_o, 1'b1, "relate");
      adv = 1'b0;
      @(negedge clk_sys_i);
      chk(relate_allowed_o, 1'b0, "relate");
      adv = 1'b1;
      chk(cmd_answer_unrelated_o, 1'b0, "answer");
      rx(FC_GROUP_KEY, 1'b0, 1'b0, DROP_MISSING_PROT);
      rx(FC_DATA, 1'b1, 1'b0, DROP_UNEXPECTED_PROT);
      tx(FC_DATA, 1'b0, 1'b1, 1'b0, 12'h000);
      chk(tx_block_o, 1'b1, "tx_block");
      complete_run;
   end
   initial begin
      repeat (2000) @(posedge clk_sys_i);
      num_errors++;
      complete_run;
   end
endmodule // tb_top
bind frame_security_policy_filter frame_security_props props (.clk_sys_i, .rst_n_i, .sec_mode_i,
   .pairwise_key_installed_i, .tx_valid_i, .tx_req_i, .tx_valid_o, .tx_dec_o, .rx_valid_i,
   .rx_req_i, .rx_accept_o, .rx_drop_o, .rx_drop_cause_o, .beacon_sec_mode_o);
`default_nettype wire
